/* File: include/sfl_pkg.sv */
// shared constants and types for the switch fault logic serial port
package sfl_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NUM_OUT = 12;
  localparam int NUM_HS = 4;
  localparam int NUM_LS = 8;
  localparam int CNT_W = 22;
  localparam int BIT_W = 4;
  localparam int WORD_W = 8;

  // ***************************************************************
  // configuration word addresses and reset values
  // ***************************************************************
  localparam logic [2:0] ADDR_OPEN_LOAD = 3'h1;
  localparam logic [2:0] ADDR_OC_LIMIT = 3'h5;
  localparam logic [11:0] OPEN_LOAD_RST = 12'h000;
  localparam logic [11:0] OC_LIMIT_RST = 12'h000;
  localparam logic [2:0] ADDR_MSB = 3'h6;

  // ***************************************************************
  // timing: times in ns, counts in reference clock cycles
  // ***************************************************************
  localparam int CLK_NS = 4;
  localparam int FILTER_NS = 100000;
  localparam int PEAK_NS = 10000000;
  localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int PEAK_CYC = (PEAK_NS + CLK_NS - 1) / CLK_NS;

  // ***************************************************************
  // carriers
  // ***************************************************************
  // raw comparator levels from the power stages
  typedef struct packed {
    logic ov;
    logic [NUM_OUT-1:0] ot;
    logic [NUM_OUT-1:0] ol;
    logic [NUM_LS-1:0] oc;
  } sfl_sense_type;

  // asynchronous pins seen by the reference domain
  typedef struct packed {
    sfl_sense_type sense;
    logic cs_n;
    logic sclk;
  } sfl_pin_type;

  // serial clock domain state
  typedef struct packed {
    logic [15:0] rx;
    logic [BIT_W-1:0] bits;
    logic [WORD_W-1:0] words;
  } sfl_link_type;

  // reference clock domain state
  typedef struct packed {
    sfl_pin_type sync1;
    sfl_pin_type sync2;
    logic cs_d;
    logic sclk_d;
    logic skip;
    logic echo;
    logic rx_valid;
    logic fault_n;
    logic so;
    logic so_oe;
    logic [NUM_OUT-1:0] cmd_d;
    logic [NUM_OUT-1:0] stat;
    logic [NUM_OUT-1:0] out_on;
    logic [NUM_OUT-1:0] ol_cfg;
    logic [NUM_OUT-1:0] oc_lim_cfg;
    logic [NUM_HS-1:0] hs_ot_hold;
    logic [NUM_HS-1:0] peak;
    logic [NUM_LS-1:0] ls_ot_latch;
    logic [NUM_LS-1:0] ls_oc_latch;
    logic [NUM_LS-1:0] ls_pin;
    logic [15:0] tx;
    logic [15:0] rx_word;
    logic [BIT_W-1:0] start_bits;
    logic [WORD_W-1:0] start_words;
    logic [NUM_LS-1:0][CNT_W-1:0] filt;
    logic [NUM_HS-1:0][CNT_W-1:0] pct;
  } sfl_ref_type;

endpackage : sfl_pkg

/* File: rtl/sfl_core.sv */
// fault latching, fault pin and serial port for twelve power switches
//
// Function
// - each fault latches a one in that output's status bit; clean outputs read zero
// - status bit clears on chip-select rise only if its fault is gone
// - thermal, open-load, overcurrent per output; overvoltage global; overcurrent low side only
// - low-side overcurrent (on) and open-load (off) pass a filter delay first
// - fault pin low on any fault; real time for overvoltage and high side
// - low-side fault pin latch clears on command toggle or reset
// - overtemperature checked only while on; shuts only that output
// - low-side thermal shutdown stays off until commanded off and cooled
// - high-side thermal shutdown retries by itself once cooled
// - overvoltage forces all outputs off and sets all twelve status bits
// - open load checked only when off and enabled; high zero, low one
// - high-side open-load bit clears once load returns or output commanded on
// - after reset open-load detect on for high side, off for low side
// - low-side shutdown enable bit; zero also suppresses overcurrent reporting
// - overcurrent with shutdown enabled starts timer, then turns off and latches
// - overcurrent latch retried only by off then on command
// - shutdown disabled: output stays in current limit, no fault recorded
// - limit select zero: peak level then sustain after peak time
// - input sampled on serial clock fall, output shifted on rise
// - chip select high: clock and input ignored, output not driven
// - received word applied on chip-select rise; status loaded on fall
// - frames not a multiple of sixteen bits are discarded
`timescale 1ns/100ps
module sfl_core #(
  parameter int FILTER_CYC = sfl_pkg::FILTER_CYC,
  parameter int PEAK_CYC = sfl_pkg::PEAK_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire sfl_pkg::sfl_sense_type i_sense,
  input wire logic [sfl_pkg::NUM_OUT-1:0] i_cmd_on,
  output logic [sfl_pkg::NUM_OUT-1:0] o_out_on,
  output logic [sfl_pkg::NUM_HS-1:0] o_hs_peak_limit,
  output logic o_fault_pin_n,
  output logic o_so,
  output logic o_so_oe,
  output logic [15:0] o_rx_word,
  output logic o_rx_valid
);
  import sfl_pkg::*;

  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILTER_CYC - 1);
  localparam logic [CNT_W-1:0] PEAK_END = CNT_W'(PEAK_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  sfl_link_type lk_r;
  sfl_link_type lk_nxt;
  sfl_ref_type st_r;
  sfl_ref_type st_nxt;
  sfl_sense_type sns;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic frame_ok;
  logic [NUM_OUT-1:0] ol_cond;
  logic [NUM_OUT-1:0] present;
  logic [NUM_OUT-1:0] ev;

  // ***************************************************************
  // serial clock domain
  // ***************************************************************
  // shift in on the falling edge while selected; count bits and words
  always_comb begin
    lk_nxt = lk_r;
    if (!i_cs_n) begin
      lk_nxt.rx = {lk_r.rx[14:0], i_si}; // msb first
      lk_nxt.bits = lk_r.bits + BIT_W'(1);
      if (lk_r.bits == {BIT_W{1'b1}}) begin
        lk_nxt.words = lk_r.words + WORD_W'(1);
      end
    end
  end

  // this clock stops between frames, so reset cannot wait for an edge
  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ***************************************************************
  // reference clock domain
  // ***************************************************************
  assign sns = st_r.sync2.sense;

  // next state of all fault, output and port logic
  always_comb begin
    logic hs;
    logic on;
    logic tog;
    logic cond;
    logic acc;
    logic oc_ev;
    logic ot_ev;
    int j;
    hs = 1'b0;
    on = 1'b0;
    tog = 1'b0;
    cond = 1'b0;
    acc = 1'b0;
    oc_ev = 1'b0;
    ot_ev = 1'b0;
    j = 0;
    st_nxt = st_r;
    ol_cond = '0;
    present = '0;
    ev = '0;
    // two-stage synchronisers for pins
    st_nxt.sync1.sense = i_sense;
    st_nxt.sync1.cs_n = i_cs_n;
    st_nxt.sync1.sclk = i_sclk;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.cs_d = st_r.sync2.cs_n;
    st_nxt.sclk_d = st_r.sync2.sclk;
    st_nxt.cmd_d = i_cmd_on;
    cs_rise = st_r.sync2.cs_n & ~st_r.cs_d;
    cs_fall = ~st_r.sync2.cs_n & st_r.cs_d;
    sclk_rise = st_r.sync2.sclk & ~st_r.sclk_d;
    // link words are still while the clock is held low
    frame_ok = (lk_r.bits == st_r.start_bits) &&
               (lk_r.words != st_r.start_words);
    // per-output fault handling
    for (int i = 0; i < NUM_OUT; i++) begin
      hs = (i < NUM_HS);
      on = st_r.out_on[i];
      tog = i_cmd_on[i] ^ st_r.cmd_d[i];
      ot_ev = on & sns.ot[i];
      oc_ev = 1'b0;
      // open load only while off and enabled
      ol_cond[i] = ~on & sns.ol[i] &
                   (hs ? ~st_r.ol_cfg[i] : st_r.ol_cfg[i]);
      if (hs) begin
        // thermal hold drops as soon as it cools
        st_nxt.hs_ot_hold[i] = ot_ev | (st_r.hs_ot_hold[i] & sns.ot[i]);
        ev[i] = ot_ev | ol_cond[i];
        present[i] = sns.ot[i] | ol_cond[i];
        st_nxt.pct[i] = on ? st_r.pct[i] : '0;
        if (on && st_r.pct[i] != PEAK_END) begin
          st_nxt.pct[i] = st_r.pct[i] + CNT_ONE;
        end
        st_nxt.out_on[i] = i_cmd_on[i] & ~sns.ov &
                           ~st_nxt.hs_ot_hold[i];
        st_nxt.peak[i] = st_nxt.out_on[i] & ~st_r.oc_lim_cfg[i] &
                         (st_nxt.pct[i] < PEAK_END);
      end else begin
        j = i - NUM_HS;
        // shutdown enable gates detection and reporting
        cond = on ? (sns.oc[j] & st_r.oc_lim_cfg[i]) : ol_cond[i];
        acc = cond && (st_r.filt[j] == FILT_LAST);
        st_nxt.filt[j] = '0;
        if (cond && !acc) begin
          st_nxt.filt[j] = st_r.filt[j] + CNT_ONE;
        end else if (acc) begin
          st_nxt.filt[j] = st_r.filt[j];
        end
        oc_ev = acc & on;
        // thermal latch waits for cooling and an off command
        st_nxt.ls_ot_latch[j] = ot_ev | (st_r.ls_ot_latch[j] &
                                ~(~i_cmd_on[i] & ~sns.ot[i]));
        // overcurrent latch released only by an off command
        st_nxt.ls_oc_latch[j] = oc_ev |
                                (st_r.ls_oc_latch[j] & i_cmd_on[i]);
        ev[i] = ot_ev | oc_ev | (acc & ~on);
        // pin latch: set wins over the toggle clear
        st_nxt.ls_pin[j] = ev[i] | (st_r.ls_pin[j] & ~tog);
        present[i] = sns.ot[i] | ol_cond[i] | st_r.ls_oc_latch[j];
        st_nxt.out_on[i] = i_cmd_on[i] & ~sns.ov &
                           ~st_nxt.ls_ot_latch[j] &
                           ~st_nxt.ls_oc_latch[j];
      end
      ev[i] = ev[i] | sns.ov; // global fault
      present[i] = present[i] | sns.ov;
      // status: set wins, clear only when gone
      st_nxt.stat[i] = ev[i] |
                       (st_r.stat[i] & ~(cs_rise & ~present[i]));
    end
    // fault pin, real time plus low-side latches
    st_nxt.fault_n = ~(sns.ov | (|ol_cond[NUM_HS-1:0]) |
                       (|st_nxt.hs_ot_hold) | (|st_nxt.ls_pin));
    // apply a whole frame on chip-select rise
    st_nxt.rx_valid = 1'b0;
    if (cs_rise && frame_ok) begin
      st_nxt.rx_valid = 1'b1;
      st_nxt.rx_word = lk_r.rx;
      st_nxt.echo = lk_r.rx[15];
      if (lk_r.rx[14:12] == ADDR_OPEN_LOAD) begin
        st_nxt.ol_cfg = lk_r.rx[11:0];
      end
      if (lk_r.rx[14:12] == ADDR_OC_LIMIT) begin
        st_nxt.oc_lim_cfg = lk_r.rx[11:0];
      end
    end
    // load status on chip-select fall
    if (cs_fall) begin
      st_nxt.start_bits = lk_r.bits;
      st_nxt.start_words = lk_r.words;
      st_nxt.tx = {st_r.echo, 3'h0, st_r.stat};
      st_nxt.skip = 1'b1;
    end else if (sclk_rise && !st_r.sync2.cs_n) begin
      // first rise keeps the leading bit on the line
      st_nxt.skip = 1'b0;
      if (!st_r.skip) begin
        st_nxt.tx = {st_r.tx[14:0], 1'b0};
      end
    end
    st_nxt.so = st_nxt.tx[15];
    st_nxt.so_oe = ~st_r.sync2.cs_n;
  end

  // state register with synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.sync1.cs_n <= 1'b1;
      st_r.sync2.cs_n <= 1'b1;
      st_r.cs_d <= 1'b1;
      st_r.fault_n <= 1'b1;
      st_r.ol_cfg <= OPEN_LOAD_RST;
      st_r.oc_lim_cfg <= OC_LIMIT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign o_out_on = st_r.out_on;
  assign o_hs_peak_limit = st_r.peak;
  assign o_fault_pin_n = st_r.fault_n;
  assign o_so = st_r.so;
  assign o_so_oe = st_r.so_oe;
  assign o_rx_word = st_r.rx_word;
  assign o_rx_valid = st_r.rx_valid;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_ov_off;
    sns.ov |=> (st_r.out_on == '0) && (&st_r.stat);
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("overvoltage did not force off and flag all");

  property p_ls_ot_off;
    (st_r.out_on[4] && sns.ot[4]) |=> !st_r.out_on[4] && st_r.stat[4];
  endproperty
  a_ls_ot_off: assert property (p_ls_ot_off)
    else $error("low-side thermal fault did not shut off");

  property p_ls_ot_hold;
    (st_r.ls_ot_latch[0] && i_cmd_on[4]) |=> !st_r.out_on[4];
  endproperty
  a_ls_ot_hold: assert property (p_ls_ot_hold)
    else $error("low-side thermal latch released while on");

  property p_hs_ot_pin;
    (st_r.out_on[0] && sns.ot[0]) |=> !st_r.out_on[0] && !o_fault_pin_n;
  endproperty
  a_hs_ot_pin: assert property (p_hs_ot_pin)
    else $error("high-side thermal fault not shown");

  property p_stat_clear;
    (cs_rise && !present[0] && !ev[0]) |=> !st_r.stat[0];
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status bit not cleared on select rise");

  property p_stat_keep;
    (st_r.stat[5] && !cs_rise) |=> st_r.stat[5];
  endproperty
  a_stat_keep: assert property (p_stat_keep)
    else $error("status bit dropped without select rise");

  property p_bad_frame;
    (cs_rise && !frame_ok) |=> !o_rx_valid && $stable(st_r.ol_cfg);
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("short frame was applied");

  property p_so_idle;
    (st_r.sync2.cs_n && st_r.cs_d) |=> !o_so_oe;
  endproperty
  a_so_idle: assert property (p_so_idle)
    else $error("serial output driven while deselected");

  property p_oc_off;
    st_r.ls_oc_latch[0] |-> !st_r.out_on[4] && !o_fault_pin_n;
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("overcurrent latch with output on");

  property p_peak;
    ($rose(st_r.out_on[1]) && !st_r.oc_lim_cfg[1]) |-> o_hs_peak_limit[1];
  endproperty
  a_peak: assert property (p_peak)
    else $error("peak limit missing at switch-on");

  property p_filter_first;
    $rose(st_r.ls_oc_latch[0]) |-> st_r.filt[0] == FILT_LAST;
  endproperty
  a_filter_first: assert property (p_filter_first)
    else $error("overcurrent latched before the filter ran out");

  property p_pin_toggle;
    (st_r.ls_pin[0] && (i_cmd_on[4] ^ st_r.cmd_d[4]) && !ev[4]) |=>
      !st_r.ls_pin[0];
  endproperty
  a_pin_toggle: assert property (p_pin_toggle)
    else $error("fault pin latch kept after command toggle");

  property p_oc_retry;
    (st_r.ls_oc_latch[0] && !i_cmd_on[4]) |=> !st_r.ls_oc_latch[0];
  endproperty
  a_oc_retry: assert property (p_oc_retry)
    else $error("overcurrent latch kept after off command");

  property p_oc_quiet;
    (!st_r.oc_lim_cfg[4] && st_r.out_on[4]) |=> !st_r.ls_oc_latch[0];
  endproperty
  a_oc_quiet: assert property (p_oc_quiet)
    else $error("overcurrent latched with shutdown disabled");

  property p_hs_cool;
    (st_r.hs_ot_hold[0] && !sns.ot[0]) |=> !st_r.hs_ot_hold[0];
  endproperty
  a_hs_cool: assert property (p_hs_cool)
    else $error("high-side thermal hold kept after cooling");

  c_frame: cover property (cs_rise && frame_ok);
  c_short: cover property (cs_rise && !frame_ok);
  c_ov: cover property (sns.ov ##1 !sns.ov);
  c_oc: cover property ($rose(st_r.ls_oc_latch[0]));
  c_hs_retry: cover property ($fell(st_r.hs_ot_hold[0]));

endmodule : sfl_core

/* File: verification/sfl_host.sv */
// host serial master model driving frames into the fault logic port
`timescale 1ns/100ps
module sfl_host (
  input wire logic i_so,
  input wire logic i_so_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si
);
  // idle: deselected, clock parked low, data pulled down
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // n bits of w, msb first, 48 ns clock only inside the frame
  task automatic frame(input logic [31:0] w, input int n,
                       output logic [15:0] rd);
    o_cs_n = 1'b0; // clock held low at select change
    #24;
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_si = w[i]; // msb first, any number of bits
      #24;
      o_sclk = 1'b0;
      rd = {rd[14:0], i_so_oe ? i_so : 1'bx}; // read on falling edge
      #24;
    end
    o_cs_n = 1'b1; // clock still low at deselect
    o_si = 1'b0; // released line falls to pull-down
  endtask : frame
endmodule : sfl_host

/* File: verification/switch_fault_logic_serial_port_test.sv */
// self-checking bench for the switch fault logic serial port
`timescale 1ns/100ps
module switch_fault_logic_serial_port_test;
  import sfl_pkg::*;
  localparam int F = 8;
  logic ref_clk, rst_n, sclk, cs_n, si, so, so_oe, rx_valid, pin_n, echo;
  logic [11:0] cmd, out_on;
  logic [3:0] peak;
  logic [15:0] rx_word;
  logic [15:0] q[$];
  logic [31:0] r;
  sfl_sense_type sense;
  int n_errors = 0;
  int checked = 0;

  sfl_core #(.FILTER_CYC(F), .PEAK_CYC(20)) dut (.i_ref_clk(ref_clk),
    .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
    .i_sense(sense), .i_cmd_on(cmd), .o_out_on(out_on),
    .o_hs_peak_limit(peak), .o_fault_pin_n(pin_n), .o_so(so),
    .o_so_oe(so_oe), .o_rx_word(rx_word), .o_rx_valid(rx_valid));
  sfl_host host (.i_so(so), .i_so_oe(so_oe), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_si(si));

  // ***************************************************************
  // clock, compare and closing
  // ***************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : w

  // one frame; status word compared on 16-bit frames, good frames noted for the watcher
  task automatic xfer(input logic [31:0] wd, input int n,
                      input logic [11:0] st);
    logic [15:0] rd;
    host.frame(wd, n, rd);
    if (n == 16) check(rd, {echo, 3'h0, st});
    if (n % 16 == 0) begin
      q.push_back(wd[15:0]);
      echo = wd[15];
    end
    w(8);
  endtask : xfer

  // watcher: each accepted word matches the oldest note, away from the edge
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) check(rx_word, q.size() ? q.pop_front() : 'x);
  end

  // watchdog sized well past the whole sequence
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    rst_n = 1'b1;
    cmd = 12'h000;
    sense = '0;
    echo = 1'b0;
    void'($urandom(46));
    // reset falls after time zero so the link flops see the edge
    @(negedge ref_clk);
    rst_n = 1'b0;
    w(4);
    rst_n = 1'b1;
    w(4);
    check(16'(out_on), 16'h0000);
    check({15'h0, pin_n}, 16'h0001);
    xfer(32'h0, 16, 12'h000);
    $display("test reset done");
    // overvoltage forces all off and flags every output
    cmd = 12'hFFF;
    w(4);
    check(16'(out_on), 16'h0FFF);
    sense.ov = 1'b1;
    w(5);
    check(16'(out_on), 16'h0000);
    check({15'h0, pin_n}, 16'h0000);
    sense.ov = 1'b0;
    w(5);
    check(16'(out_on), 16'h0FFF);
    check({15'h0, pin_n}, 16'h0001);
    xfer(32'h0, 16, 12'hFFF);
    xfer(32'h0, 16, 12'h000);
    $display("test overvoltage done");
    // thermal on one low and one high output
    sense.ot = 12'h011;
    w(5);
    check(16'(out_on), 16'h0FEE);
    check({15'h0, pin_n}, 16'h0000);
    sense.ot = 12'h000;
    w(5);
    check(16'(out_on), 16'h0FEF);
    check({15'h0, pin_n}, 16'h0000);
    cmd[4] = 1'b0;
    w(4);
    cmd[4] = 1'b1;
    w(5);
    check(16'(out_on), 16'h0FFF);
    check({15'h0, pin_n}, 16'h0001);
    xfer(32'h0, 16, 12'h011);
    xfer(32'h0, 16, 12'h000);
    $display("test thermal done");
    // open load: high side on by default, low side off
    cmd = 12'hFDB;
    sense.ol = 12'h024;
    w(F + 8);
    check({15'h0, pin_n}, 16'h0000);
    xfer(32'h0, 16, 12'h004);
    sense.ol[2] = 1'b0;
    w(5);
    check({15'h0, pin_n}, 16'h0001);
    xfer(32'h1020, 16, 12'h004);
    w(F + 8);
    check({15'h0, pin_n}, 16'h0000);
    xfer(32'h0, 16, 12'h020);
    sense.ol = 12'h000;
    w(4);
    cmd = 12'hFFF;
    w(5);
    check({15'h0, pin_n}, 16'h0001);
    xfer(32'h1000, 16, 12'h020);
    $display("test open load done");
    // overcurrent with shutdown, retry, then current-limit mode
    xfer(32'h5010, 16, 12'h000);
    sense.oc[0] = 1'b1;
    w(F + 8);
    check(16'(out_on), 16'h0FEF);
    check({15'h0, pin_n}, 16'h0000);
    sense.oc[0] = 1'b0;
    w(5);
    check(16'(out_on), 16'h0FEF);
    cmd[4] = 1'b0;
    w(4);
    cmd[4] = 1'b1;
    w(5);
    check(16'(out_on), 16'h0FFF);
    check({15'h0, pin_n}, 16'h0001);
    xfer(32'h5000, 16, 12'h010);
    sense.oc[0] = 1'b1;
    w(F + 8);
    check(16'(out_on), 16'h0FFF);
    check({15'h0, pin_n}, 16'h0001);
    sense.oc[0] = 1'b0;
    w(2);
    xfer(32'h0, 16, 12'h000);
    $display("test overcurrent done");
    // peak then sustain, and sustain only when selected
    for (int s = 0; s < 2; s++) begin
      xfer({20'h00005, 10'h000, s[0], 1'b0}, 16, 12'h000);
      cmd[1] = 1'b0;
      w(4);
      cmd[1] = 1'b1;
      w(4);
      check(16'(peak), s ? 16'h0000 : 16'h0002);
      w(30);
      check(16'(peak), 16'h0000);
    end
    $display("test peak done");
    // long, short and random frames
    r = $urandom;
    xfer({r[31:16], r[15], 3'h6, r[11:0]}, 32, 12'h000);
    xfer(32'h7FFF, 15, 12'h000);
    xfer(32'h0, 16, 12'h000);
    check(16'(q.size()), 16'h0000);
    $display("test frames done");
    stop_test();
  end
endmodule : switch_fault_logic_serial_port_test
